/* File: common/vcs_pkg.sv */
// shared constants and types for the vco calibration sequencer
package vcs_pkg;

  // register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] VCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] VCS_OFS_TIMEOUT = 8'h04;
  localparam logic [7:0] VCS_OFS_LOCK_TIMEOUT = 8'h08;
  localparam logic [7:0] VCS_OFS_LEVEL_WAIT = 8'h0c;
  localparam logic [7:0] VCS_OFS_BAND_DIV = 8'h10;
  localparam logic [7:0] VCS_OFS_INT_VALUE = 8'h14;
  localparam logic [7:0] VCS_OFS_STATUS = 8'h18;

  // control register bit positions
  localparam int VCS_CTRL_DOUBLER_BIT = 0;
  localparam int VCS_CTRL_HALVE_BIT = 1;
  localparam int VCS_CTRL_AUTOCAL_BIT = 2;
  localparam int VCS_CTRL_W = 3;

  // field widths
  localparam int VCS_TIMEOUT_W = 10;
  localparam int VCS_LOCK_W = 5;
  localparam int VCS_LEVEL_W = 5;
  localparam int VCS_BAND_DIV_W = 8;
  localparam int VCS_INT_W = 16;
  localparam int VCS_CNT_W = 24;
  localparam int VCS_PERIOD_W = VCS_BAND_DIV_W + 4;

  // reset values
  localparam logic [VCS_CTRL_W-1:0] VCS_CTRL_RST = 3'h4;
  localparam logic [VCS_TIMEOUT_W-1:0] VCS_TIMEOUT_RST = 10'h067;
  localparam logic [VCS_LOCK_W-1:0] VCS_LOCK_RST = 5'h0c;
  localparam logic [VCS_LEVEL_W-1:0] VCS_LEVEL_RST = 5'h1e;
  localparam logic [VCS_BAND_DIV_W-1:0] VCS_BAND_DIV_RST = 8'h1a;
  localparam logic [VCS_INT_W-1:0] VCS_INT_RST = 16'h0000;

  // timing factors of the calibration phases
  localparam logic [4:0] VCS_BAND_MULT = 5'h10;
  localparam logic [3:0] VCS_BAND_CYCLES = 4'hb;
  localparam logic [5:0] VCS_LEVEL_MULT = 6'h37; // five times eleven

  // calibration phases, one-hot
  typedef enum logic [3:0] {
    VCS_IDLE = 4'b0001,
    VCS_SETTLE = 4'b0010,
    VCS_BAND = 4'b0100,
    VCS_LEVEL = 4'b1000
  } vcs_phase_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } vcs_bus_req_t;

endpackage

/* File: rtl/vcs_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable every period cycles while run is high
module vcs_tick_div
  import vcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [VCS_PERIOD_W-1:0] period,
  output logic tick
);

  logic [VCS_PERIOD_W-1:0] count; // cycles since last tick

  // restarts from zero whenever run drops, so phase is fresh per use
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      count <= '0;
    end else if (tick) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // a period of 0 or 1 ticks every cycle
  assign tick = run && (count + 1'b1 >= period);

endmodule
`default_nettype wire

/* File: rtl/vcs_sequencer.sv */
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - settle wait lasts timeout times lock cycles
// - settle wait leads straight into band select
// - band clock is clock over sixteen times divider
// - band select lasts exactly eleven band clocks
// - level calibration lasts 5*11*wait*timeout cycles
// - doubler gives two reference events per period
// - halving gives 50% duty comparison signal with doubler off; with doubler on it keeps the reference duty
// - integer write applies frequency, starts calibration
module vcs_sequencer
  import vcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire vcs_bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic ref_in,
  output logic pfd_ref,
  output logic [VCS_INT_W-1:0] freq_int,
  output logic tune_force,
  output logic band_select,
  output logic level_calibration,
  output logic cal_busy,
  output logic band_tick
);

  // software visible settings
  logic [VCS_CTRL_W-1:0] ctrl;
  logic [VCS_TIMEOUT_W-1:0] timeout_count;
  logic [VCS_LOCK_W-1:0] lock_timeout_count;
  logic [VCS_LEVEL_W-1:0] level_wait_count;
  logic [VCS_BAND_DIV_W-1:0] band_select_divider;

  // sequencer state
  vcs_phase_t phase;
  vcs_phase_t next_phase;
  logic [VCS_CNT_W-1:0] cnt; // cycles spent in the current phase
  logic [3:0] band_count; // band clocks seen in band select
  logic int_write; // integer register written this cycle

  // reference path
  logic ref_s1; // first synchroniser stage
  logic ref_s2; // second synchroniser stage
  logic ref_d; // previous synchronised level
  logic ref_rise;
  logic ref_fall;
  logic ref_evt; // reference event after the doubler

  // phase lengths widened to the counter; band clock period at VCS_PERIOD_W
  logic [VCS_CNT_W-1:0] settle_len;
  logic [VCS_CNT_W-1:0] level_len;
  logic [VCS_PERIOD_W-1:0] band_period;
  logic settle_done;
  logic level_done;

  assign int_write = bus_req.we && (bus_req.addr == VCS_OFS_INT_VALUE);

  // phase lengths are computed at full counter width and the band period at VCS_PERIOD_W, so no setting overflows
  assign settle_len = VCS_CNT_W'(timeout_count) * VCS_CNT_W'(lock_timeout_count);
  assign level_len = VCS_CNT_W'(VCS_LEVEL_MULT) * VCS_CNT_W'(level_wait_count)
    * VCS_CNT_W'(timeout_count);
  assign band_period = VCS_PERIOD_W'(band_select_divider) * VCS_PERIOD_W'(VCS_BAND_MULT);

  // a zero length still spends one cycle in the phase
  assign settle_done = (cnt + 1'b1 >= settle_len);
  assign level_done = (cnt + 1'b1 >= level_len);

  // band select clock, only running during band select
  vcs_tick_div u_band_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(phase == VCS_BAND),
    .period(band_period),
    .tick(band_tick)
  );

  // register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= VCS_CTRL_RST;
      timeout_count <= VCS_TIMEOUT_RST;
      lock_timeout_count <= VCS_LOCK_RST;
      level_wait_count <= VCS_LEVEL_RST;
      band_select_divider <= VCS_BAND_DIV_RST;
    end else if (bus_req.we) begin
      unique case (bus_req.addr)
        VCS_OFS_CTRL: begin
          ctrl <= bus_req.wdata[VCS_CTRL_W-1:0];
        end
        VCS_OFS_TIMEOUT: begin
          timeout_count <= bus_req.wdata[VCS_TIMEOUT_W-1:0];
        end
        VCS_OFS_LOCK_TIMEOUT: begin
          lock_timeout_count <= bus_req.wdata[VCS_LOCK_W-1:0];
        end
        VCS_OFS_LEVEL_WAIT: begin
          level_wait_count <= bus_req.wdata[VCS_LEVEL_W-1:0];
        end
        VCS_OFS_BAND_DIV: begin
          band_select_divider <= bus_req.wdata[VCS_BAND_DIV_W-1:0];
        end
        default: begin
          // other offsets hold no setting
        end
      endcase
    end
  end

  // the applied frequency changes only on an integer write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      freq_int <= VCS_INT_RST;
    end else if (int_write) begin
      freq_int <= bus_req.wdata[VCS_INT_W-1:0];
    end
  end

  // read data, valid the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (sys_rst || !bus_req.re) begin
      rdata <= '0;
    end else begin
      unique case (bus_req.addr)
        VCS_OFS_CTRL: rdata <= 32'(ctrl);
        VCS_OFS_TIMEOUT: rdata <= 32'(timeout_count);
        VCS_OFS_LOCK_TIMEOUT: rdata <= 32'(lock_timeout_count);
        VCS_OFS_LEVEL_WAIT: rdata <= 32'(level_wait_count);
        VCS_OFS_BAND_DIV: rdata <= 32'(band_select_divider);
        VCS_OFS_INT_VALUE: rdata <= 32'(freq_int);
        VCS_OFS_STATUS: rdata <= {27'h0, cal_busy, phase};
        default: rdata <= '0; // unmapped reads as zero
      endcase
    end
  end

  // phase sequencing; an integer write during calibration restarts it
  always_comb begin
    next_phase = phase;
    if (int_write) begin
      next_phase = ctrl[VCS_CTRL_AUTOCAL_BIT] ? VCS_SETTLE : VCS_IDLE;
    end else begin
      unique case (phase)
        VCS_IDLE: next_phase = VCS_IDLE;
        VCS_SETTLE: begin
          if (settle_done) begin
            next_phase = VCS_BAND;
          end
        end
        VCS_BAND: begin
          if (band_tick && band_count == VCS_BAND_CYCLES - 1'b1) begin
            next_phase = VCS_LEVEL;
          end
        end
        VCS_LEVEL: begin
          if (level_done) begin
            next_phase = VCS_IDLE;
          end
        end
        default: next_phase = VCS_IDLE; // illegal code recovers to idle
      endcase
    end
  end

  // phase register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= VCS_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // per-phase cycle counter, cleared on every phase change
  always_ff @(posedge clk) begin
    if (sys_rst || next_phase != phase || int_write) begin
      cnt <= '0;
    end else if (phase != VCS_IDLE) begin
      cnt <= cnt + 1'b1;
    end
  end

  // band clocks counted within band select
  always_ff @(posedge clk) begin
    if (sys_rst || phase != VCS_BAND) begin
      band_count <= '0;
    end else if (band_tick) begin
      band_count <= band_count + 1'b1;
    end
  end

  // phase outputs from the state register
  assign tune_force = (phase == VCS_SETTLE);
  assign band_select = (phase == VCS_BAND);
  assign level_calibration = (phase == VCS_LEVEL);
  assign cal_busy = (phase != VCS_IDLE);

  // reference pin synchroniser; only ref_s2 reads ref_s1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_d <= 1'b0;
    end else begin
      ref_s1 <= ref_in;
      ref_s2 <= ref_s1;
      ref_d <= ref_s2;
    end
  end

  assign ref_rise = ref_s2 && !ref_d;
  assign ref_fall = !ref_s2 && ref_d;
  // both edges give twice the event rate of the reference
  assign ref_evt = ctrl[VCS_CTRL_DOUBLER_BIT] ? (ref_rise || ref_fall)
    : ref_rise;

  // halving toggles per event (even duty with doubler off, reference duty with it on); else one pulse per event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pfd_ref <= 1'b0;
    end else if (ctrl[VCS_CTRL_HALVE_BIT]) begin
      pfd_ref <= pfd_ref ^ ref_evt;
    end else begin
      pfd_ref <= ref_evt;
    end
  end

  // helper: cycles between band clocks
  logic [VCS_PERIOD_W-1:0] band_gap;
  always_ff @(posedge clk) begin
    if (sys_rst || phase != VCS_BAND || band_tick) begin
      band_gap <= '0;
    end else begin
      band_gap <= band_gap + 1'b1;
    end
  end

  sequence s_settle_end;
    phase == VCS_SETTLE && !int_write && settle_done;
  endsequence

  sequence s_band_last;
    phase == VCS_BAND && !int_write && band_tick
      && band_count == VCS_BAND_CYCLES - 1'b1;
  endsequence

  a_settle_length: assert property (@(posedge clk) disable iff (sys_rst)
    phase == VCS_SETTLE && !int_write && !settle_done |=> phase == VCS_SETTLE)
    else $error("settle phase ended early");
  a_settle_to_band: assert property (@(posedge clk) disable iff (sys_rst)
    s_settle_end |=> phase == VCS_BAND && cnt == '0)
    else $error("settle did not lead into band select");
  a_band_clock_gap: assert property (@(posedge clk) disable iff (sys_rst)
    phase == VCS_BAND && band_tick && band_period > 1
      |-> band_gap == band_period - 1'b1)
    else $error("band clock period wrong");
  a_band_eleven: assert property (@(posedge clk) disable iff (sys_rst)
    s_band_last |=> phase == VCS_LEVEL ##1 band_count == '0)
    else $error("band select length wrong");
  a_level_exit: assert property (@(posedge clk) disable iff (sys_rst)
    phase == VCS_LEVEL && !int_write |=> (phase == VCS_IDLE) == $past(level_done))
    else $error("level calibration length wrong");
  a_doubler_fall: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[VCS_CTRL_DOUBLER_BIT] && !ctrl[VCS_CTRL_HALVE_BIT] && ref_fall
      |=> pfd_ref)
    else $error("doubler missed falling edge");
  a_halve_toggle: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl[VCS_CTRL_HALVE_BIT] && ref_evt |=> pfd_ref != $past(pfd_ref))
    else $error("halved reference did not toggle");
  a_int_start: assert property (@(posedge clk) disable iff (sys_rst)
    int_write |=> freq_int == $past(bus_req.wdata[VCS_INT_W-1:0])
      && cal_busy == $past(ctrl[VCS_CTRL_AUTOCAL_BIT]))
    else $error("integer write not applied");
  a_idle_stays: assert property (@(posedge clk) disable iff (sys_rst)
    phase == VCS_IDLE && !int_write |=> phase == VCS_IDLE && $stable(freq_int))
    else $error("calibration started without integer write");

endmodule
`default_nettype wire

/* File: test/vcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side: register port master and reference source
module vcs_host_model
  import vcs_pkg::*;
(
  input wire logic clk,
  output var vcs_bus_req_t bus_req,
  output var logic ref_in,
  input wire logic [31:0] rdata
);
  localparam int FPFD_KHZ = 200000; // the block clock is the pfd clock
  logic [31:0] div_ok, lw_ok, to_ok, lk_ok; // counts a careful host picks

  // idle port and quiet reference from time zero
  initial begin
    bus_req = '0;
    ref_in = 1'b0;
  end

  // one write cycle, strobe dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus_req.we <= 1'b0;
  endtask

  // one read cycle; data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus_req.re <= 1'b0;
    #1 d = rdata;
  endtask

  // legal counts; too long to simulate, so only programmed
  task automatic program_legal;
    div_ok = (FPFD_KHZ + 2399) / 2400;
    lw_ok = 32'h1f;
    to_ok = (FPFD_KHZ / 20 + lw_ok - 1) / lw_ok;
    lk_ok = (FPFD_KHZ / 50 + to_ok - 1) / to_ok;
    wr(VCS_OFS_BAND_DIV, div_ok);
    wr(VCS_OFS_LEVEL_WAIT, lw_ok);
    wr(VCS_OFS_TIMEOUT, to_ok);
    wr(VCS_OFS_LOCK_TIMEOUT, lk_ok);
  endtask

  // n reference edges, 20 clocks apart, changed just after a clock edge
  task automatic ref_burst(input int n);
    repeat (n) begin
      repeat (20) @(posedge clk);
      ref_in <= ~ref_in;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/vcs_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the calibration sequencer
module vcs_sequencer_test
  import vcs_pkg::*;
;
  logic clk, sys_rst, ref_in, pfd_ref, pfd_prev, tune_force;
  logic band_select, level_calibration, cal_busy, band_tick;
  logic [31:0] rdata, d;
  logic [VCS_INT_W-1:0] freq_int;
  vcs_bus_req_t bus_req;
  int n_fail = 0, check_count = 0;
  int rises = 0, highs = 0, r0, h0; // pfd reference activity
  // map walk: offsets and reset values, last one unmapped
  logic [7:0] ofs [8] = '{VCS_OFS_CTRL, VCS_OFS_TIMEOUT,
    VCS_OFS_LOCK_TIMEOUT, VCS_OFS_LEVEL_WAIT, VCS_OFS_BAND_DIV,
    VCS_OFS_INT_VALUE, VCS_OFS_STATUS, 8'h1c};
  int rv [8] = '{4, 'h67, 'hc, 'h1e, 'h1a, 0, 1, 0};
  // timeout, lock, divider, level wait per calibration run
  int cfg [2][4] = '{'{1, 2, 1, 1}, '{2, 3, 2, 1}};
  // control modes: halve, both, plain, doubler
  logic [2:0] md [4] = '{3'h2, 3'h3, 3'h0, 3'h1};
  int xr [4] = '{4, 8, 8, 16};
  int xh [4] = '{160, 160, 8, 16};

  vcs_sequencer dut_u (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rdata(rdata), .ref_in(ref_in), .pfd_ref(pfd_ref),
    .freq_int(freq_int), .tune_force(tune_force),
    .band_select(band_select), .level_calibration(level_calibration),
    .cal_busy(cal_busy), .band_tick(band_tick));
  vcs_host_model host_u (.clk(clk), .bus_req(bus_req), .ref_in(ref_in),
    .rdata(rdata));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // count rising edges and high cycles of the pfd reference
  always @(posedge clk) begin
    pfd_prev <= pfd_ref;
    if (pfd_ref === 1'b1) highs <= highs + 1;
    if (pfd_ref === 1'b1 && pfd_prev === 1'b0) rises <= rises + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // start a calibration and time every phase from the outside
  task automatic run_cal(input int st, input int bd, input int lv);
    int ns = 0, nb = 0, nl = 0, nt = 0, nx = 0;
    host_u.wr(VCS_OFS_INT_VALUE, 32'h5a5a);
    #1;
    chk("freq_int", 32'h5a5a, {16'h0, freq_int});
    for (int i = 0; i < 2000 && cal_busy !== 1'b0; i++) begin
      ns += (tune_force === 1'b1);
      nb += (band_select === 1'b1);
      nl += (level_calibration === 1'b1);
      nt += (band_tick === 1'b1);
      nx += (cal_busy !== (tune_force | band_select | level_calibration));
      @(posedge clk);
      #1;
    end
    chk("settle cycles", st, ns);
    chk("band cycles", bd, nb);
    chk("band ticks", 11, nt);
    chk("level cycles", lv, nl);
    chk("phase gaps", 0, nx);
    chk("busy after", 0, cal_busy);
  endtask

  // watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, status and an unmapped word
    foreach (ofs[i]) begin
      host_u.rd(ofs[i], d);
      chk("reset value", rv[i], d);
    end
    // realistic counts only programmed and read back
    host_u.program_legal();
    host_u.rd(VCS_OFS_BAND_DIV, d);
    chk("band div", host_u.div_ok, d);
    host_u.rd(VCS_OFS_LEVEL_WAIT, d);
    chk("level wait", host_u.lw_ok, d);
    host_u.rd(VCS_OFS_LOCK_TIMEOUT, d);
    chk("lock timeout", host_u.lk_ok, d);
    host_u.rd(VCS_OFS_TIMEOUT, d);
    chk("timeout", host_u.to_ok, d);
    // short counts keep each calibration to a few hundred cycles
    foreach (cfg[i]) begin
      host_u.wr(VCS_OFS_TIMEOUT, cfg[i][0]);
      host_u.wr(VCS_OFS_LOCK_TIMEOUT, cfg[i][1]);
      host_u.wr(VCS_OFS_BAND_DIV, cfg[i][2]);
      host_u.wr(VCS_OFS_LEVEL_WAIT, cfg[i][3]);
      run_cal(cfg[i][0] * cfg[i][1], 176 * cfg[i][2],
        55 * cfg[i][3] * cfg[i][0]);
    end
    // a second integer write in mid band select restarts from settle
    host_u.wr(VCS_OFS_INT_VALUE, 32'h1);
    repeat (20) @(posedge clk);
    run_cal(6, 352, 110);
    host_u.rd(VCS_OFS_STATUS, d);
    chk("status idle", 32'h1, d);
    // autocalibration off: frequency applied, no calibration
    host_u.wr(VCS_OFS_CTRL, 32'h0);
    host_u.wr(VCS_OFS_INT_VALUE, 32'h1234);
    #1;
    chk("freq_int", 32'h1234, {16'h0, freq_int});
    chk("busy off", 0, cal_busy);
    host_u.wr(VCS_OFS_TIMEOUT, 32'h77);
    #1;
    chk("freq hold", 32'h1234, {16'h0, freq_int});
    // fresh reset so the halving flop starts low; held over two edges
    // so checks looking one cycle back see only reset values
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (md[i]) begin
      host_u.wr(VCS_OFS_CTRL, {29'h0, md[i]});
      r0 = rises;
      h0 = highs;
      host_u.ref_burst(16);
      repeat (10) @(posedge clk);
      chk("pfd rises", xr[i], rises - r0);
      chk("pfd high cycles", xh[i], highs - h0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
